// ### design/boundary_scan_tap.sv
// Purpose: Boundary-scan test access port, run from the system clock
// Assumes: Test clock much slower than clk_sys; pins are asynchronous;
//          core_levels come from logic on clk_sys
// Notes: Test clock edges are found by sampling, so timing lags by
//        three system clocks behind each test clock edge; the test
//        clock must stay high and low for three system clocks or more.
//        Pin levels pass their own two-stage synchroniser, so a level
//        must settle a few system clocks before Capture-DR.
// Behaviour
// - Three-bit instruction, shifted in LSB first
// - Code 000 chain selected, pins driven from latch
// - Code 100 chain captures pins ORed with core, normal path kept
// - Code 110 selects identification register
// - Code 111 bypass, one test clock delay
// - Identification shifts out LSB first
// - Identification 32 bits, bit 0 one
// - Bypass register is one bit
// - 98-bit chain, only under EXTEST or SAMPLE
// - Sixteen-state controller, DR and IR branches
// - Transitions follow TMS at rising test clock
// - Data in on TDI, out on TDO
// - Five TMS-high edges reach reset state
// - Reset state loads IDCODE, normal operation
// - Chain latch updates on falling edge only
`timescale 1ns/100ps
`include "tap_cfg.svh"
module boundary_scan_tap #(
    parameter int BSC_LEN = `TAP_BSC_LEN
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire tap_pkg::tap_pins_t pins,
    input wire logic [BSC_LEN-1:0] pin_levels,
    input wire logic [BSC_LEN-1:0] core_levels,
    output logic tdo,
    output logic tdo_oe,
    output logic [BSC_LEN-1:0] pin_drive,
    output logic test_mode
);
    // Synchroniser, controller and scan register state
    tap_pkg::tap_pins_t sync1_q;
    tap_pkg::tap_pins_t sync2_q;
    logic tck_prev_q;
    logic rise;
    logic fall;
    tap_pkg::tap_state_t state_q;
    logic [`TAP_IR_W-1:0] instruction_shift_register;
    logic [`TAP_IR_W-1:0] instr_q;
    logic [`TAP_ID_W-1:0] identification_shift_register;
    logic single_bit_passthrough_register;
    logic [BSC_LEN-1:0] boundary_cell_chain;
    logic [BSC_LEN-1:0] chain_latch_q;
    logic [BSC_LEN-1:0] pin_sync1_q;
    logic [BSC_LEN-1:0] pin_sync2_q;
    logic [BSC_LEN-1:0] capture_vec;
    logic [2:0] tms_high_q;
    logic [1:0] sel_d;
    logic serial_d;

    // Shared decode: which data register the instruction picks
    // A function keeps all users of this decode in step
    // 0 chain, 1 identification, 2 bypass
    function automatic logic [1:0] dr_select(input logic [2:0] op);
        case (op)
            `TAP_OP_EXTEST, `TAP_OP_SAMPLE: dr_select = 2'h0;
            `TAP_OP_IDCODE: dr_select = 2'h1;
            default: dr_select = 2'h2;
        endcase
    endfunction

    // Two stages before any logic looks at the pins
    // The last stage feeds the edge detector, which idles low like TCK
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            tck_prev_q <= sync2_q.tck;
        end
    end

    // One-clock strobes on each detected test clock edge
    assign rise = sync2_q.tck & ~tck_prev_q;
    assign fall = ~sync2_q.tck & tck_prev_q;

    // Pin levels are asynchronous too; each bit is only sampled as a
    // static level, so per-bit synchronisers suffice without a handshake
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_sync1_q <= '0;
            pin_sync2_q <= '0;
        end else begin
            pin_sync1_q <= pin_levels;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // Five TMS-high rises in a row force the reset state even if the
    // state register was upset, so a tester can always recover the port;
    // the count saturates once reached
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tms_high_q <= 3'h0;
        end else if (rise) begin
            if (!sync2_q.tms) begin
                tms_high_q <= 3'h0;
            end else if (tms_high_q != `TAP_RESET_RISES) begin
                tms_high_q <= tms_high_q + 3'h1;
            end
        end
    end

    // Controller steps on each rising test clock edge
    // Two branches: data register scans and instruction register scans
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= tap_pkg::ST_RESET;
        end else if (rise && sync2_q.tms &&
                     tms_high_q == `TAP_RESET_RISES - 3'h1) begin
            state_q <= tap_pkg::ST_RESET;
        end else if (rise) begin
            case (state_q)
                tap_pkg::ST_RESET: state_q <= sync2_q.tms ?
                    tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
                tap_pkg::ST_IDLE: state_q <= sync2_q.tms ?
                    tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
                tap_pkg::ST_CAP_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_SH_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_EX1_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_UPD_DR : tap_pkg::ST_PAU_DR;
                tap_pkg::ST_PAU_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_EX2_DR : tap_pkg::ST_PAU_DR;
                tap_pkg::ST_EX2_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
                tap_pkg::ST_UPD_DR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                tap_pkg::ST_SEL_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
                tap_pkg::ST_CAP_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_SH_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_EX1_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_UPD_IR : tap_pkg::ST_PAU_IR;
                tap_pkg::ST_PAU_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_EX2_IR : tap_pkg::ST_PAU_IR;
                tap_pkg::ST_EX2_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
                tap_pkg::ST_UPD_IR: state_q <= sync2_q.tms ?
                    tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
                default: state_q <= tap_pkg::ST_RESET;
            endcase
        end
    end

    // Instruction shift stages; the active code changes on falling edge
    // in Update-IR, or to IDCODE in reset, so it never glitches during a shift
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            instruction_shift_register <= `TAP_IR_CAPTURE;
            instr_q <= `TAP_OP_IDCODE;
        end else begin
            if (rise && state_q == tap_pkg::ST_CAP_IR) begin
                instruction_shift_register <= `TAP_IR_CAPTURE;
            end else if (rise && state_q == tap_pkg::ST_SH_IR) begin
                instruction_shift_register <= {sync2_q.tdi,
                    instruction_shift_register[`TAP_IR_W-1:1]};
            end
            if (state_q == tap_pkg::ST_RESET) begin
                instr_q <= `TAP_OP_IDCODE;
            end else if (fall && state_q == tap_pkg::ST_UPD_IR) begin
                instr_q <= instruction_shift_register;
            end
        end
    end

    // Identification register: fixed pattern captured, LSB out first
    // Capture reloads the pattern, so a scan never returns stale data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            identification_shift_register <= '0;
        end else if (rise && dr_select(instr_q) == 2'h1) begin
            if (state_q == tap_pkg::ST_CAP_DR) begin
                identification_shift_register <= {`TAP_ID_REV,
                    `TAP_ID_PART, `TAP_ID_PRODUCER,
                    `TAP_ID_FIXED_BIT};
            end else if (state_q == tap_pkg::ST_SH_DR) begin
                identification_shift_register <= {sync2_q.tdi,
                    identification_shift_register[`TAP_ID_W-1:1]};
            end
        end
    end

    // Bypass: one stage, captures zero
    // The captured zero lets a tester count devices along a chain
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            single_bit_passthrough_register <= 1'b0;
        end else if (rise && dr_select(instr_q) == 2'h2) begin
            if (state_q == tap_pkg::ST_CAP_DR) begin
                single_bit_passthrough_register <= 1'b0;
            end else if (state_q == tap_pkg::ST_SH_DR) begin
                single_bit_passthrough_register <= sync2_q.tdi;
            end
        end
    end

    // Capture source of the chain; SAMPLE folds the core side into the
    // same cell since each cell keeps a single capture value
    always_comb begin
        capture_vec = pin_sync2_q;
        if (instr_q == `TAP_OP_SAMPLE) begin
            capture_vec = pin_sync2_q | core_levels;
        end
    end

    // Boundary chain: EXTEST samples pins, SAMPLE samples core side too
    // Only the chain instructions touch it, so other scans leave it alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boundary_cell_chain <= '0;
        end else if (rise && dr_select(instr_q) == 2'h0) begin
            if (state_q == tap_pkg::ST_CAP_DR) begin
                boundary_cell_chain <= capture_vec;
            end else if (state_q == tap_pkg::ST_SH_DR) begin
                boundary_cell_chain <= {sync2_q.tdi,
                    boundary_cell_chain[BSC_LEN-1:1]};
            end
        end
    end

    // Parallel latch moves only in Update-DR on the falling edge
    // Holding it through shifts keeps the pins quiet during a scan
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chain_latch_q <= '0;
        end else if (fall && state_q == tap_pkg::ST_UPD_DR &&
                     dr_select(instr_q) == 2'h0) begin
            chain_latch_q <= boundary_cell_chain;
        end
    end

    // Test mode flag: EXTEST active and the controller out of reset
    // Entering reset drops it on the same system clock as the instruction reloads
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            test_mode <= 1'b0;
        end else begin
            test_mode <= (instr_q == `TAP_OP_EXTEST) &&
                (state_q != tap_pkg::ST_RESET);
        end
    end

    // Pins follow the core except under EXTEST; registered so the pins
    // never see a glitch while the instruction or the latch changes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_drive <= '0;
        end else begin
            pin_drive <= (instr_q == `TAP_OP_EXTEST &&
                state_q != tap_pkg::ST_RESET) ?
                chain_latch_q : core_levels;
        end
    end

    // Serial output source, from current path
    // Shift-IR overrides the data path so the capture pattern shows
    always_comb begin
        sel_d = dr_select(instr_q);
        if (state_q == tap_pkg::ST_SH_IR) begin
            serial_d = instruction_shift_register[0];
        end else if (sel_d == 2'h0) begin
            serial_d = boundary_cell_chain[0];
        end else if (sel_d == 2'h1) begin
            serial_d = identification_shift_register[0];
        end else begin
            serial_d = single_bit_passthrough_register;
        end
    end

    // TDO changes on the falling test clock edge, as a tester expects
    // The tester samples it just before the next rise, long settled
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (fall) begin
            tdo <= serial_d;
            tdo_oe <= (state_q == tap_pkg::ST_SH_DR) ||
                (state_q == tap_pkg::ST_SH_IR);
        end
    end
endmodule // boundary_scan_tap

// ### design/tap_cfg.svh
// Purpose: Constants of the boundary-scan test port
// Assumes: Included by the package and the port module
// Notes: Definitions only
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH
`define TAP_IR_W 3
`define TAP_ID_W 32
`define TAP_BSC_LEN 98
`define TAP_OP_EXTEST 3'h0
`define TAP_OP_SAMPLE 3'h4
`define TAP_OP_IDCODE 3'h6
`define TAP_OP_BYPASS 3'h7
`define TAP_IR_CAPTURE 3'h1
`define TAP_RESET_RISES 3'h5
`define TAP_ID_FIXED_BIT 1'h1
// Identity fields hold arbitrary values that name no maker or part
`define TAP_ID_PRODUCER 11'h000
`define TAP_ID_PART 16'h0000
`define TAP_ID_REV 4'h0
`endif

// ### design/tap_pkg.sv
// Purpose: Types of the boundary-scan test port
// Assumes: tap_cfg.svh holds the numbers
// Notes: States are one-hot
`include "tap_cfg.svh"
package tap_pkg;
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_state_t;
    // Pins of the test port as seen from the outside
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;
endpackage

// ### tb/boundary_scan_tap_bench.sv
// Purpose: Self-checking bench of the boundary-scan test port
// Assumes: Tester model paces the test clock
// Notes: Values are checked after the closing idle step
`timescale 1ns/100ps
`include "tap_cfg.svh"
module boundary_scan_tap_bench;
    localparam int N = 98;
    localparam logic [N-1:0] PA = {49{2'h2}};
    localparam logic [N-1:0] PB = {14{7'h13}};
    localparam logic [N-1:0] PS = {7{14'h2c5a}};
    localparam logic [31:0] ID = {`TAP_ID_REV, `TAP_ID_PART,
        `TAP_ID_PRODUCER, `TAP_ID_FIXED_BIT};
    logic clk_sys, rst_n, tdo, tdo_oe, test_mode;
    tap_pkg::tap_pins_t pins;
    logic [N-1:0] pin_levels, core_levels, pin_drive, got;
    int bad_count = 0;
    int checked = 0;
    // System clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    boundary_scan_tap #(.BSC_LEN(N)) boundary_scan_tap_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .pins(pins), .pin_levels(pin_levels),
        .core_levels(core_levels), .tdo(tdo), .tdo_oe(tdo_oe),
        .pin_drive(pin_drive), .test_mode(test_mode));
    tap_tester tap_tester_i (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe),
        .pins(pins));
    task automatic cmp(input logic [N-1:0] g, input logic [N-1:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_flag(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t: flag got %b want %b", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("bad_count %0d checked %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic load_ir(input logic [2:0] c);
        tap_tester_i.scan(1'b1, 3, N'(c), got);
        cmp(got, N'(`TAP_IR_CAPTURE));
    endtask
    task automatic t_idcode();
        tap_tester_i.scan(1'b0, 32, '0, got);
        cmp(got, N'(ID));
    endtask
    // Every code that must fall back to the one-bit path
    task automatic t_bypass();
        logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            tap_tester_i.scan(1'b0, 8, 98'h00b4, got);
            cmp(got & 98'h00ff, 98'h0068);
        end
    endtask
    task automatic t_extest();
        load_ir(`TAP_OP_EXTEST);
        tap_tester_i.scan(1'b0, N, PS, got);
        cmp(got, PA);
        cmp(pin_drive, PS);
        cmp_flag(test_mode, 1'b1);
    endtask
    // Preload under sample must show on the pins once EXTEST returns
    task automatic t_sample();
        load_ir(`TAP_OP_SAMPLE);
        cmp_flag(test_mode, 1'b0);
        tap_tester_i.scan(1'b0, N, ~PS, got);
        cmp(got, PA | PB);
        cmp(pin_drive, PB);
        load_ir(`TAP_OP_EXTEST);
        cmp(pin_drive, ~PS);
    endtask
    // A pause inside a chain scan must lose and repeat no bit
    task automatic t_pause();
        load_ir(`TAP_OP_SAMPLE);
        tap_tester_i.scan_paused(N, 40, PS, got);
        cmp(got, PA | PB);
        load_ir(`TAP_OP_EXTEST);
        cmp(pin_drive, PS);
    endtask
    task automatic t_reset();
        tap_tester_i.reset_tap();
        cmp_flag(test_mode, 1'b0);
        cmp(pin_drive, PB);
        t_idcode();
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        pin_levels = PA;
        core_levels = PB;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        tap_tester_i.reset_tap();
        t_idcode();
        t_bypass();
        t_extest();
        t_sample();
        t_pause();
        t_reset();
        summarize();
    end
    // Watchdog, several times the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end
endmodule // boundary_scan_tap_bench
bind boundary_scan_tap tap_props #(.BSC_LEN(BSC_LEN)) tap_props_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .pin_levels(pin_levels),
    .core_levels(core_levels), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_drive(pin_drive), .test_mode(test_mode));

// ### tb/tap_props.sv
// Purpose: Port checks of the boundary-scan test port
// Assumes: Test clock levels last four or more system clocks
// Notes: Edge figures allow for the pin synchroniser delay
`timescale 1ns/100ps
module tap_props #(
    parameter int BSC_LEN = 98
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire tap_pkg::tap_pins_t pins,
    input wire logic [BSC_LEN-1:0] pin_levels,
    input wire logic [BSC_LEN-1:0] core_levels,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [BSC_LEN-1:0] pin_drive,
    input wire logic test_mode
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Outputs clear on reset and follow the core; serial, latch changes and mode rises trail a test clock fall
    AST_RST_VAL: assert property (disable iff (1'b0) !rst_n |=>
        !tdo && !tdo_oe && !test_mode && pin_drive == '0)
        else $error("outputs not cleared by reset");
    AST_CORE_PATH: assert property (!test_mode && $past(!test_mode)
        && $past(rst_n) |-> pin_drive == $past(core_levels))
        else $error("core levels not passed to pins");
    AST_TDO_FALL: assert property ($changed(tdo) |->
        !$past(pins.tck) && $past(pins.tck, 5))
        else $error("serial out moved off a test clock fall");
    AST_OE_FALL: assert property ($changed(tdo_oe) |->
        !$past(pins.tck) && $past(pins.tck, 5))
        else $error("output enable moved off a test clock fall");
    AST_LATCH_FALL: assert property (test_mode && $past(test_mode)
        && $changed(pin_drive) |-> !$past(pins.tck) && $past(pins.tck, 5))
        else $error("pin latch moved off a test clock fall");
    AST_TDO_STANDS: assert property ($changed(tdo) |=>
        $stable(tdo) [*3])
        else $error("serial out did not stand");
    AST_MODE_RISE: assert property ($rose(test_mode) |->
        !$past(pins.tck) && $past(pins.tck, 5))
        else $error("test mode began off a test clock fall");
    AST_OE_STANDS: assert property ($rose(tdo_oe) |=> tdo_oe [*3])
        else $error("output enable did not stand");
endmodule // tap_props

// ### tb/tap_tester.sv
// Purpose: Model of the external boundary-scan tester
// Assumes: Called just after a falling system clock edge
// Notes: TCK stands low between steps, 800 ns a step
`timescale 1ns/100ps
module tap_tester (
    input wire logic clk_sys,
    input wire logic tdo,
    input wire logic tdo_oe,
    output tap_pkg::tap_pins_t pins
);
    initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    // One test clock; TDO is read late in the low phase, long settled
    task automatic step(input logic tms, input logic tdi, output logic so);
        pins.tms = tms;
        pins.tdi = tdi;
        repeat (4) @(negedge clk_sys);
        // A released line reads as the opposite of its last level
        so = tdo_oe ? tdo : ~tdo;
        pins.tck = 1'b1;
        repeat (4) @(negedge clk_sys);
        pins.tck = 1'b0;
    endtask
    // Scan from Run-Test/Idle back to Run-Test/Idle
    task automatic scan(input logic ir, input int len,
        input logic [97:0] din, output logic [97:0] dout);
        logic so;
        dout = '0;
        step(1'b1, 1'b0, so);
        if (ir)
            step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
        step(1'b0, 1'b0, so);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, din[i], so);
            dout[i] = so;
        end
        step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
    endtask
    // Data scan with a pause after bit at, through Exit2 back to Shift
    task automatic scan_paused(input int len, input int at,
        input logic [97:0] din, output logic [97:0] dout);
        logic so;
        dout = '0;
        step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
        step(1'b0, 1'b0, so);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1 || i == at, din[i], so);
            dout[i] = so;
            if (i == at) begin
                step(1'b0, 1'b0, so);
                step(1'b0, 1'b0, so);
                step(1'b1, 1'b0, so);
                step(1'b0, 1'b0, so);
            end
        end
        step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
    endtask
    // Five high steps reach reset from anywhere, then park in idle
    task automatic reset_tap();
        logic so;
        repeat (5) step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
    endtask
endmodule // tap_tester
